/* File: inc/flash_restart_defines.svh */
// constants for the flash restart sequencer: timing counts, register map and field positions
`ifndef FLASH_RESTART_DEFINES_SVH
`define FLASH_RESTART_DEFINES_SVH

`define CLOCK_FREQ_MHZ 10
`define CLOCK_PERIOD_NS 100

`define POWER_UP_SETTLE_TIME_US 300
`define POWER_UP_SETTLE_CYCLES (`POWER_UP_SETTLE_TIME_US * `CLOCK_FREQ_MHZ)
`define RESTART_RECOVERY_TIME_US 30
`define RESTART_RECOVERY_CYCLES (`RESTART_RECOVERY_TIME_US * `CLOCK_FREQ_MHZ)
`define RESTART_PULSE_WIDTH_NS 200
`define RESTART_PULSE_CYCLES ((`RESTART_PULSE_WIDTH_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define EXTENSION_TICK_PERIOD_US 30
`define EXTENSION_TICK_CYCLES (`EXTENSION_TICK_PERIOD_US * `CLOCK_FREQ_MHZ)
`define SLEEP_EXIT_TIME_US 100
`define SLEEP_EXIT_CYCLES (`SLEEP_EXIT_TIME_US * `CLOCK_FREQ_MHZ)

`define EXT_COUNT_OFFSET 12'h000
`define STATUS_OFFSET 12'h004
`define CONTROL_OFFSET 12'h008
`define NV_BUS_CONFIG_OFFSET 12'h00c

`define EXT_COUNT_RESET 16'hffff
`define NV_BUS_CONFIG_RESET 16'h0000

`define STATUS_PROGRAMMED_BIT 0
`define STATUS_PROGRAM_FAIL_BIT 1
`define STATUS_POR_OK_BIT 2
`define STATUS_STATE_LSB 8
`define CONTROL_SLEEP_ENTER_BIT 0
`define CONTROL_MARK_POR_BAD_BIT 1

`define SYNC_RESTART_N_BIT 0
`define SYNC_SELECT_N_BIT 1
`define SYNC_LOCKOUT_BIT 2
`define SYNC_POWER_GOOD_BIT 3

`endif

/* File: inc/flash_restart_pkg.sv */
// types shared by the flash restart sequencer and its interval timer
package flash_restart_pkg;

    typedef enum logic [3:0] {
        st_off,
        st_cold,
        st_extend,
        st_hw_reset,
        st_standby,
        st_sleep,
        st_wake
    } restart_state_t;

    typedef struct packed {
        restart_state_t state;
        logic [3:0] meta;
        logic [3:0] sync;
        logic por_ok;
        logic otp_used;
        logic prog_fail;
        logic sleep_req;
        logic [8:0] rec_left;
        logic [1:0] low_cnt;
        logic [15:0] ext_count;
        logic [15:0] nv_bus_config;
        logic [15:0] bus_config;
        logic [31:0] prdata;
        logic abort_pulse;
        logic alt_exit_pulse;
        logic status_clear_pulse;
        logic warm_start_pulse;
        logic cold_start_pulse;
    } core_state_t;

    typedef struct packed {
        logic [16:0] remaining;
        logic [8:0] pre;
        logic use_ticks;
        logic busy;
        logic done;
    } timer_state_t;

endpackage : flash_restart_pkg

/* File: inc/timer_if.sv */
// carrier between the sequencer and its interval timer
`timescale 1ns/1ns
interface timer_if;
    logic start;
    logic use_ticks;
    logic [16:0] count;
    logic busy;
    logic done;

    modport ctrl (output start, output use_ticks, output count, input busy, input done);
    modport timer (input start, input use_ticks, input count, output busy, output done);
endinterface : timer_if

/* File: rtl/interval_timer.sv */
// interval timer: counts clock cycles or 30 us ticks prescaled from the clock and flags the end
`timescale 1ns/1ns
`include "flash_restart_defines.svh"
module interval_timer
    import flash_restart_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    timer_if.timer tif
);

    timer_state_t s;
    timer_state_t next_s;
    logic step;

    assign tif.busy = s.busy;
    assign tif.done = s.done;

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        step = 1'b0;
        if (tif.start) begin
            // prescaler restarts so the first tick is a whole period
            next_s.remaining = tif.count;
            next_s.pre = 9'h000;
            next_s.use_ticks = tif.use_ticks;
            next_s.busy = (tif.count != 17'h00000);
        end else if (s.busy) begin
            if (s.use_ticks) begin
                step = (s.pre == 9'(`EXTENSION_TICK_CYCLES - 1));
                next_s.pre = step ? 9'h000 : s.pre + 9'h001;
            end else begin
                step = 1'b1;
            end
            if (step) begin
                next_s.remaining = s.remaining - 17'h00001;
                if (s.remaining == 17'h00001) begin
                    next_s.busy = 1'b0;
                    next_s.done = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

endmodule : interval_timer

/* File: rtl/flash_restart_sequencer.sv */
// flash power-on and warm restart sequencer with apb register access
//
// Overview of operation
// R1 - ignore restart input and select during power-on interval and extension
// R2 - in power-on or restart-out low: no commands, not selectable, outputs float
// R3 - optional restart pulse during power-on; finish at later of interval and recovery
// R4 - restart low at interval end holds hardware reset, high goes to standby
// R5 - hardware reset after an improper power-on runs the cold algorithm instead
// R6 - open-drain restart output low during power-on, released then standby at once
// R7 - sixteen-bit nonvolatile extension count; erased ffff adds no extension
// R8 - programmed extension keeps restart output low value plus one slow ticks
// R9 - extension count is one-time programmable; later attempts fail
// R10 - interrupt output is high impedance once supply reaches minimum
// R11 - hardware reset aborts work, leaves alternate space, floats outputs, clears status
// R12 - select ignored for whole recovery time; host keeps select high meanwhile
// R13 - while restart input low host issues nothing and device blocks commands
// R14 - hardware reset reloads bus configuration from nonvolatile configuration
// R15 - after power-on, hardware reset runs short warm algorithm without reload
// R16 - after warm algorithm stay in reset while input low, else standby
// R17 - host holds restart low 200 ns and high 150 ns before select
// R18 - host issues no transactions during the 300 us power-up interval
// R19 - if restart stays low past interval, recovery is measured from interval end
// R20 - host keeps select high at least 6 ns between operations
// R21 - restart pulse of minimum width wakes from deepest sleep with default settings
// R22 - below lockout threshold all program and erase operations are inhibited
// R23 - sleep exit takes between 1 and 300 us, commands ignored throughout
// R24 - intervals timed by counters on an internal free-running time base
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ns
`include "flash_restart_defines.svh"
module flash_restart_sequencer
    import flash_restart_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic power_good,
    input wire logic vcc_below_lockout,
    input wire logic restart_in_n,
    input wire logic select_n,
    output logic system_restart_out_n_out,
    output logic system_restart_out_n_oe_n,
    output logic irq_out_n_out,
    output logic irq_out_n_oe_n,
    output logic select_accepted,
    output logic command_enable,
    output logic outputs_float,
    output logic program_erase_inhibit,
    output logic abort_operation,
    output logic exit_alternate_space,
    output logic clear_status,
    output logic warm_algorithm_start,
    output logic cold_algorithm_start,
    output logic [15:0] bus_config,
    output logic [3:0] state_code,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    localparam core_state_t CORE_RESET = '{
        state: st_off,
        meta: 4'h0,
        sync: 4'h0,
        por_ok: 1'b0,
        otp_used: 1'b0,
        prog_fail: 1'b0,
        sleep_req: 1'b0,
        rec_left: 9'h000,
        low_cnt: 2'h0,
        ext_count: `EXT_COUNT_RESET,
        nv_bus_config: `NV_BUS_CONFIG_RESET,
        bus_config: `NV_BUS_CONFIG_RESET,
        prdata: 32'h00000000,
        abort_pulse: 1'b0,
        alt_exit_pulse: 1'b0,
        status_clear_pulse: 1'b0,
        warm_start_pulse: 1'b0,
        cold_start_pulse: 1'b0
    };

    core_state_t s;
    core_state_t next_s;

    timer_if tmr ();

    logic t_start;
    logic t_ticks;
    logic [16:0] t_count;
    logic restart_low;
    logic select_low;
    logic lockout;
    logic pgood;
    logic apb_setup;
    logic apb_write;
    logic mapped;
    logic nv_write_ok;

    function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] offset);
        reg_hit = (addr[11:2] == offset[11:2]);
    endfunction : reg_hit

    // where power-on, extension or sleep exit ends up once its interval is over
    function automatic restart_state_t settle(input logic low, input logic [8:0] rec);
        if (low || rec != 9'h000) begin
            settle = st_hw_reset;
        end else begin
            settle = st_standby;
        end
    endfunction : settle

    interval_timer u_timer (
        .clock(clock),
        .rst_b(rst_b),
        .tif(tmr)
    );

    assign tmr.start = t_start;
    assign tmr.use_ticks = t_ticks;
    assign tmr.count = t_count;

    assign restart_low = !s.sync[`SYNC_RESTART_N_BIT];
    assign select_low = !s.sync[`SYNC_SELECT_N_BIT];
    assign lockout = s.sync[`SYNC_LOCKOUT_BIT];
    assign pgood = s.sync[`SYNC_POWER_GOOD_BIT];

    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pwrite;
    assign mapped = reg_hit(paddr, `EXT_COUNT_OFFSET) || reg_hit(paddr, `STATUS_OFFSET)
                    || reg_hit(paddr, `CONTROL_OFFSET) || reg_hit(paddr, `NV_BUS_CONFIG_OFFSET);
    // nonvolatile writes only while idle and above the lockout threshold
    assign nv_write_ok = (s.state == st_standby) && !lockout; // R22

    always_comb begin
        next_s = s;
        t_start = 1'b0;
        t_ticks = 1'b0;
        t_count = 17'h00000;

        next_s.meta = {power_good, vcc_below_lockout, select_n, restart_in_n};
        next_s.sync = s.meta;

        next_s.abort_pulse = 1'b0;
        next_s.alt_exit_pulse = 1'b0;
        next_s.status_clear_pulse = 1'b0;
        next_s.warm_start_pulse = 1'b0;
        next_s.cold_start_pulse = 1'b0;

        if (!restart_low) begin
            next_s.low_cnt = 2'h0;
        end else if (s.low_cnt != 2'h3) begin
            next_s.low_cnt = s.low_cnt + 2'h1;
        end

        if (s.rec_left != 9'h000) begin
            next_s.rec_left = s.rec_left - 9'h001;
        end

        unique case (s.state)
            st_off: begin
                if (pgood) begin
                    next_s.state = st_cold;
                    next_s.por_ok = 1'b0;
                    next_s.rec_left = 9'h000;
                    next_s.cold_start_pulse = 1'b1;
                    next_s.bus_config = s.nv_bus_config;
                    t_start = 1'b1;
                    t_count = 17'(`POWER_UP_SETTLE_CYCLES); // R24
                end
            end
            st_cold: begin
                // a pulse here only pushes out the finish; it is not a reset of its own
                if (restart_low) begin
                    next_s.rec_left = 9'(`RESTART_RECOVERY_CYCLES); // R3
                end
                if (tmr.done) begin
                    next_s.por_ok = 1'b1;
                    if (s.ext_count != `EXT_COUNT_RESET) begin
                        next_s.state = st_extend; // R7
                        t_start = 1'b1;
                        t_ticks = 1'b1;
                        t_count = {1'b0, s.ext_count} + 17'h00001; // R8
                    end else begin
                        next_s.state = settle(restart_low, s.rec_left); // R4
                        if (restart_low) begin
                            next_s.rec_left = 9'(`RESTART_RECOVERY_CYCLES); // R19
                        end
                    end
                end
            end
            st_extend: begin
                // restart input is not looked at until the extension has run out
                if (tmr.done) begin
                    next_s.state = settle(restart_low, s.rec_left); // R1
                    if (restart_low) begin
                        next_s.rec_left = 9'(`RESTART_RECOVERY_CYCLES); // R19
                    end
                end
            end
            st_hw_reset: begin
                if (!restart_low && s.rec_left == 9'h000) begin
                    next_s.state = st_standby; // R16
                end
            end
            st_standby: begin
                if (restart_low) begin
                    next_s.abort_pulse = 1'b1; // R11
                    next_s.alt_exit_pulse = 1'b1; // R11
                    next_s.status_clear_pulse = 1'b1; // R11
                    next_s.prog_fail = 1'b0; // R11
                    next_s.bus_config = s.nv_bus_config; // R14
                    next_s.sleep_req = 1'b0;
                    if (!s.por_ok) begin
                        next_s.state = st_cold; // R5
                        next_s.cold_start_pulse = 1'b1;
                        next_s.rec_left = 9'h000;
                        t_start = 1'b1;
                        t_count = 17'(`POWER_UP_SETTLE_CYCLES);
                    end else begin
                        next_s.state = st_hw_reset; // R15
                        next_s.warm_start_pulse = 1'b1;
                        next_s.rec_left = 9'(`RESTART_RECOVERY_CYCLES); // R12
                    end
                end else if (s.sleep_req) begin
                    next_s.state = st_sleep;
                    next_s.sleep_req = 1'b0;
                end
            end
            st_sleep: begin
                // shorter glitches are filtered so noise cannot wake the part
                if (s.low_cnt >= 2'(`RESTART_PULSE_CYCLES)) begin
                    next_s.state = st_wake; // R21
                    next_s.bus_config = s.nv_bus_config;
                    next_s.status_clear_pulse = 1'b1;
                    t_start = 1'b1;
                    t_count = 17'(`SLEEP_EXIT_CYCLES); // R23
                end
            end
            st_wake: begin
                if (tmr.done) begin
                    next_s.state = settle(restart_low, s.rec_left);
                    if (restart_low) begin
                        next_s.rec_left = 9'(`RESTART_RECOVERY_CYCLES);
                    end
                end
            end
        endcase

        // loss of supply overrides every state
        if (!pgood) begin
            next_s.state = st_off;
            next_s.por_ok = 1'b0;
            next_s.sleep_req = 1'b0;
        end

        if (apb_setup) begin
            next_s.prdata = 32'h00000000;
            if (reg_hit(paddr, `EXT_COUNT_OFFSET)) begin
                next_s.prdata[15:0] = s.ext_count;
            end else if (reg_hit(paddr, `STATUS_OFFSET)) begin
                next_s.prdata[`STATUS_PROGRAMMED_BIT] = s.otp_used;
                next_s.prdata[`STATUS_PROGRAM_FAIL_BIT] = s.prog_fail;
                next_s.prdata[`STATUS_POR_OK_BIT] = s.por_ok;
                next_s.prdata[`STATUS_STATE_LSB +: 4] = s.state;
            end else if (reg_hit(paddr, `CONTROL_OFFSET)) begin
                next_s.prdata[`CONTROL_SLEEP_ENTER_BIT] = s.sleep_req;
            end else if (reg_hit(paddr, `NV_BUS_CONFIG_OFFSET)) begin
                next_s.prdata[15:0] = s.nv_bus_config;
            end
        end

        if (apb_write) begin
            if (reg_hit(paddr, `STATUS_OFFSET) && pwdata[`STATUS_PROGRAM_FAIL_BIT]) begin
                next_s.prog_fail = 1'b0;
            end
            if (reg_hit(paddr, `EXT_COUNT_OFFSET)) begin
                if (!s.otp_used && nv_write_ok) begin
                    next_s.ext_count = pwdata[15:0];
                    next_s.otp_used = 1'b1; // R9
                end else begin
                    next_s.prog_fail = 1'b1; // R9
                end
            end
            if (reg_hit(paddr, `NV_BUS_CONFIG_OFFSET)) begin
                if (nv_write_ok) begin
                    next_s.nv_bus_config = pwdata[15:0];
                end else begin
                    next_s.prog_fail = 1'b1; // R22
                end
            end
            if (reg_hit(paddr, `CONTROL_OFFSET)) begin
                // sleep only from standby; a request elsewhere is dropped
                if (pwdata[`CONTROL_SLEEP_ENTER_BIT] && s.state == st_standby && !restart_low) begin
                    next_s.sleep_req = 1'b1;
                end
                if (pwdata[`CONTROL_MARK_POR_BAD_BIT]) begin
                    next_s.por_ok = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            s <= CORE_RESET;
        end else begin
            s <= next_s;
        end
    end

    // open drain: the pad only ever pulls low, the board pull-up makes the high
    assign system_restart_out_n_out = 1'b0;
    assign system_restart_out_n_oe_n = !(s.state == st_off || s.state == st_cold
                                         || s.state == st_extend); // R6
    assign irq_out_n_out = 1'b0;
    assign irq_out_n_oe_n = 1'b1; // R10

    assign command_enable = (s.state == st_standby) && !restart_low; // R13
    assign select_accepted = command_enable && select_low; // R2
    assign outputs_float = !command_enable; // R11
    assign program_erase_inhibit = lockout || (s.state != st_standby); // R22

    assign abort_operation = s.abort_pulse;
    assign exit_alternate_space = s.alt_exit_pulse;
    assign clear_status = s.status_clear_pulse;
    assign warm_algorithm_start = s.warm_start_pulse;
    assign cold_algorithm_start = s.cold_start_pulse;
    assign bus_config = s.bus_config;
    assign state_code = s.state;

    assign prdata = s.prdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

endmodule : flash_restart_sequencer

/* File: bench/flash_restart_assertions.sv */
// assertions on the restart sequencer ports
`timescale 1ns/1ns
module flash_restart_assertions (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic vcc_below_lockout,
    input wire logic restart_in_n,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic system_restart_out_n_out,
    input wire logic system_restart_out_n_oe_n,
    input wire logic irq_out_n_oe_n,
    input wire logic select_accepted,
    input wire logic command_enable,
    input wire logic outputs_float,
    input wire logic program_erase_inhibit,
    input wire logic abort_operation,
    input wire logic exit_alternate_space,
    input wire logic clear_status,
    input wire logic warm_algorithm_start,
    input wire logic cold_algorithm_start,
    input wire logic [3:0] state_code
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    logic [15:0] cold_cnt;
    // cold interval length, bounded both ways
    always_ff @(posedge clock) begin
        if (!rst_b || state_code != 4'h1) begin
            cold_cnt <= 16'h0000;
        end else begin
            cold_cnt <= cold_cnt + 16'h0001;
        end
    end
    a_select_when_open: assert property (select_accepted |-> command_enable && state_code == 4'h4)
        else $error("select while closed");
    a_outputs_float: assert property (outputs_float == !command_enable && (!command_enable || state_code == 4'h4))
        else $error("float wrong");
    a_restart_out_low: assert property (system_restart_out_n_out == 1'b0 &&
        (system_restart_out_n_oe_n == 1'b0) == (state_code <= 4'h2)) else $error("restart out wrong");
    a_irq_floats: assert property (irq_out_n_oe_n == 1'b1)
        else $error("irq driven");
    a_lockout_inhibit: assert property (vcc_below_lockout [*3] |=> program_erase_inhibit)
        else $error("no lockout inhibit");
    a_busy_inhibit: assert property (state_code != 4'h4 |-> program_erase_inhibit)
        else $error("no inhibit off standby");
    a_restart_blocks: assert property (!restart_in_n [*3] |=> !command_enable)
        else $error("commands open in restart");
    a_warm_entry: assert property (warm_algorithm_start |-> state_code == 4'h3 && $past(state_code) == 4'h4 &&
        abort_operation && exit_alternate_space && clear_status ##1 !warm_algorithm_start) else $error("bad warm entry");
    a_cold_entry: assert property (cold_algorithm_start |-> state_code == 4'h1 ##1 !cold_algorithm_start)
        else $error("bad cold entry");
    a_cold_length: assert property ($fell(state_code == 4'h1) && state_code != 4'h0 |->
        cold_cnt >= 16'd2995 && cold_cnt <= 16'd3005) else $error("cold length wrong");
    a_unmapped_err: assert property (psel && penable |-> pready &&
        pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c})) else $error("slverr wrong");
    c_extend: cover property (state_code == 4'h2);
    c_warm: cover property (warm_algorithm_start);
    c_wake: cover property (state_code == 4'h6);
    c_cold_again: cover property (cold_algorithm_start && $past(state_code) == 4'h4);
endmodule : flash_restart_assertions

bind flash_restart_sequencer flash_restart_assertions chk (.clock, .rst_b, .vcc_below_lockout, .restart_in_n,
    .paddr, .psel, .penable, .pready, .pslverr, .system_restart_out_n_out, .system_restart_out_n_oe_n,
    .irq_out_n_oe_n, .select_accepted, .command_enable, .outputs_float, .program_erase_inhibit, .abort_operation,
    .exit_alternate_space, .clear_status, .warm_algorithm_start, .cold_algorithm_start, .state_code);

/* File: bench/host_model.sv */
// host model driving the restart and select pins
`timescale 1ns/1ns
module host_model (
    input wire logic clock,
    output logic restart_in_n,
    output logic select_n
);
    // select idles high for low reset current
    initial begin
        restart_in_n = 1'b1;
        select_n = 1'b1;
    end
    task pulse(input int lo);
        @(posedge clock);
        restart_in_n <= 1'b0;
        repeat (lo) @(posedge clock);
        restart_in_n <= 1'b1;
        repeat (2) @(posedge clock);
    endtask : pulse
    task hold(input logic v);
        @(posedge clock);
        restart_in_n <= v;
    endtask : hold
    task sel(input logic v);
        @(posedge clock);
        select_n <= v;
    endtask : sel
endmodule : host_model

/* File: bench/flash_power_on_and_warm_reset_test.sv */
// self-checking bench for the restart sequencer
`timescale 1ns/1ns
`include "flash_restart_defines.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module flash_power_on_and_warm_reset_test;
    logic clock, rst_b, power_good, vcc_below_lockout, restart_in_n, select_n, oe_n, select_accepted;
    logic command_enable, program_erase_inhibit, psel, penable, pwrite, pready, pslverr, perr, warm, cold, clr, flt;
    logic [2:0] seen = 3'h0;
    logic [3:0] state_code;
    logic [15:0] bus_config;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;
    int t0;
    host_model host (.clock(clock), .restart_in_n(restart_in_n), .select_n(select_n));
    flash_restart_sequencer DUT (.clock(clock), .rst_b(rst_b), .power_good(power_good),
        .vcc_below_lockout(vcc_below_lockout), .restart_in_n(restart_in_n), .select_n(select_n),
        .system_restart_out_n_out(), .system_restart_out_n_oe_n(oe_n), .irq_out_n_out(), .irq_out_n_oe_n(),
        .select_accepted(select_accepted), .command_enable(command_enable), .outputs_float(flt),
        .program_erase_inhibit(program_erase_inhibit), .abort_operation(), .exit_alternate_space(),
        .clear_status(clr), .warm_algorithm_start(warm), .cold_algorithm_start(cold), .bus_config(bus_config),
        .state_code(state_code), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) cyc <= cyc + 1;
    always @(posedge clock) seen <= seen | {cold, warm, clr};
    task give_verdict;
        $display("checks %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    // run is about 12000 cycles
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        give_verdict;
    end
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rdat = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rdat, e)
    endtask : rd
    task wait_state(input logic [3:0] s, input int lim);
        int n;
        n = 0;
        while (state_code !== s && n < lim) begin
            @(negedge clock);
            n++;
        end
        `CHK(state_code, s)
    endtask : wait_state
    task win(input int lo, input int hi);
        `CHK((cyc - t0 >= lo && cyc - t0 <= hi), 1'b1)
    endtask : win
    task done(input string s);
        $display("test %s done", s);
    endtask : done
    initial begin
        rst_b = 1'b0;
        power_good = 1'b0;
        vcc_below_lockout = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        `CHK(oe_n, 1'b0)
        rd(`EXT_COUNT_OFFSET, 32'h0000ffff);
        rd(`NV_BUS_CONFIG_OFFSET, 32'h0);
        apb(1'b1, `EXT_COUNT_OFFSET, 32'h5);
        rd(`EXT_COUNT_OFFSET, 32'h0000ffff);
        rd(`STATUS_OFFSET, 32'h2);
        apb(1'b1, `STATUS_OFFSET, 32'h2);
        rd(12'h010, 32'h0);
        `CHK(perr, 1'b1)
        done("registers at reset");
        power_good <= 1'b1;
        t0 = cyc;
        repeat (100) @(posedge clock);
        host.sel(1'b0);
        repeat (4) @(posedge clock);
        `CHK({select_accepted, command_enable, oe_n, flt}, 4'b0001)
        host.sel(1'b1);
        wait_state(4'h4, 4000);
        win(3000, 3012);
        `CHK(oe_n, 1'b1)
        rd(`STATUS_OFFSET, 32'h404);
        host.sel(1'b0);
        repeat (4) @(posedge clock);
        `CHK(select_accepted, 1'b1)
        host.sel(1'b1);
        done("cold start");
        apb(1'b1, `EXT_COUNT_OFFSET, 32'h1);
        apb(1'b1, `EXT_COUNT_OFFSET, 32'h7);
        rd(`EXT_COUNT_OFFSET, 32'h1);
        rd(`STATUS_OFFSET, 32'h407);
        done("one-time count");
        apb(1'b1, `NV_BUS_CONFIG_OFFSET, 32'ha5);
        `CHK(bus_config, 16'h0)
        t0 = cyc;
        host.pulse(4);
        `CHK(command_enable, 1'b0)
        wait_state(4'h4, 500);
        win(300, 312);
        `CHK(bus_config, 16'h00a5)
        rd(`STATUS_OFFSET, 32'h405);
        `CHK(seen, 3'h7)
        done("warm restart");
        vcc_below_lockout <= 1'b1;
        repeat (3) @(posedge clock);
        `CHK(program_erase_inhibit, 1'b1)
        apb(1'b1, `NV_BUS_CONFIG_OFFSET, 32'h5a);
        rd(`NV_BUS_CONFIG_OFFSET, 32'ha5);
        rd(`STATUS_OFFSET, 32'h407);
        apb(1'b1, `STATUS_OFFSET, 32'h2);
        vcc_below_lockout <= 1'b0;
        repeat (3) @(posedge clock);
        `CHK(program_erase_inhibit, 1'b0)
        done("lockout");
        apb(1'b1, `CONTROL_OFFSET, 32'h1);
        wait_state(4'h5, 10);
        t0 = cyc;
        host.pulse(4);
        wait_state(4'h6, 10);
        wait_state(4'h4, 1100);
        win(1000, 1012);
        `CHK(bus_config, 16'h00a5)
        done("sleep exit");
        apb(1'b1, `CONTROL_OFFSET, 32'h2);
        t0 = cyc;
        host.pulse(4);
        wait_state(4'h1, 10);
        `CHK(oe_n, 1'b0)
        wait_state(4'h4, 4000);
        win(3600, 3615);
        done("cold after bad power-on");
        power_good <= 1'b0;
        wait_state(4'h0, 10);
        host.hold(1'b0);
        power_good <= 1'b1;
        t0 = cyc;
        wait_state(4'h2, 3100);
        wait_state(4'h3, 700);
        win(3600, 3615);
        `CHK({oe_n, command_enable}, 2'b10)
        host.hold(1'b1);
        t0 = cyc;
        wait_state(4'h4, 400);
        win(290, 312);
        done("restart held through power-on");
        give_verdict;
    end
endmodule : flash_power_on_and_warm_reset_test
